/* File: ebr_addr_port.sv */
// address register with clock enable for one memory port
`timescale 1ns/1ps
`include "ebr_regs.svh"

module ebr_addr_port
  import ebr_pkg::*;
(
  // clock and reset
  input  wire logic      clock,
  input  wire logic      rst_n,
  // request side
  input  wire ebr_req_t  req,
  input  wire logic      packed_mode,
  input  wire logic      half_sel,
  // memory side
  output      ebr_addr_t eff_addr
);

  ebr_addr_t addr_hold;
  ebr_addr_t next_addr_hold;
  ebr_addr_t raw_addr;

  // =====================================================================
  // address register
  // =====================================================================
  always_comb begin
    next_addr_hold = req.addr_ce ? req.addr : addr_hold;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_hold <= `EBR_ADDR_RST;
    end else begin
      addr_hold <= next_addr_hold;
    end
  end

  // =====================================================================
  // address used by this edge's access
  // =====================================================================
  always_comb begin
    raw_addr = req.addr_ce ? req.addr : addr_hold;
    eff_addr = raw_addr;
    if (packed_mode) begin
      eff_addr[`EBR_HALF_MSB] = half_sel;
    end
  end

endmodule : ebr_addr_port

/* File: ebr_block_ram.sv */
// embedded block ram with two synchronous ports and packed mode
`timescale 1ns/1ps
`include "ebr_regs.svh"

// Functional notes
// - In packed mode each of the two single-port memories is confined to its own half of the block.
// - Each packed memory has a data word of at most 18 bits.
// - Each packed memory does its reads and writes on the one shared clock.
// - With the address clock enable low the address register keeps its previous value.
// - Each port has its own address clock enable, independent of the other port.
// - With the output register bypassed, written data shows at the output on the write edge.
module ebr_block_ram
  import ebr_pkg::*;
(
  // clock and reset
  input  wire logic      clock,
  input  wire logic      rst_n,
  // configuration
  input  wire ebr_cfg_t  cfg,
  // port a
  input  wire ebr_req_t  req_a,
  output      ebr_data_t rdata_a,
  // port b
  input  wire ebr_req_t  req_b,
  output      ebr_data_t rdata_b,
  // status
  output      logic      collision
);

  // =====================================================================
  // storage
  // =====================================================================
  ebr_data_t mem [0:`EBR_DEPTH-1];

  ebr_req_t  req      [0:`EBR_NUM_PORTS-1];
  ebr_addr_t eff_addr [0:`EBR_NUM_PORTS-1];
  logic      bypass   [0:`EBR_NUM_PORTS-1];

  ebr_data_t rd_latch      [0:`EBR_NUM_PORTS-1];
  ebr_data_t next_rd_latch [0:`EBR_NUM_PORTS-1];
  ebr_data_t rd_out        [0:`EBR_NUM_PORTS-1];
  ebr_data_t next_rd_out   [0:`EBR_NUM_PORTS-1];
  logic      next_collision;

  always_comb begin
    req[`EBR_PORT_A]    = req_a;
    req[`EBR_PORT_B]    = req_b;
    bypass[`EBR_PORT_A] = cfg.bypass_a;
    bypass[`EBR_PORT_B] = cfg.bypass_b;
  end

  // write-first view of a port's word at this edge
  function automatic ebr_data_t port_word(input ebr_req_t r, input ebr_data_t stored);
    port_word = r.write_en ? r.wdata : stored;
  endfunction : port_word

  // =====================================================================
  // per-port address registers
  // =====================================================================
  genvar p;
  generate
    for (p = 0; p < `EBR_NUM_PORTS; p = p + 1) begin : g_port
      // separate enable per port
      ebr_addr_port u_addr (
        .clock       (clock),
        .rst_n       (rst_n),
        .req         (req[p]),
        .packed_mode (cfg.packed_mode),
        .half_sel    (1'(p)),
        .eff_addr    (eff_addr[p])
      );

      // =================================================================
      // read path
      // =================================================================
      always_comb begin
        next_rd_latch[p] = port_word(req[p], mem[eff_addr[p]]);
        if (bypass[p]) begin
          next_rd_out[p] = next_rd_latch[p];
        end else begin
          next_rd_out[p] = rd_latch[p];
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          rd_latch[p] <= `EBR_DATA_RST;
          rd_out[p]   <= `EBR_DATA_RST;
        end else begin
          rd_latch[p] <= next_rd_latch[p];
          rd_out[p]   <= next_rd_out[p];
        end
      end
    end
  endgenerate

  // =====================================================================
  // write path on the single shared clock
  // =====================================================================
  always_ff @(posedge clock) begin
    if (req[`EBR_PORT_A].write_en) begin
      mem[eff_addr[`EBR_PORT_A]] <= req[`EBR_PORT_A].wdata;
    end
    // same-address collision leaves port b's word; contents are not guaranteed
    if (req[`EBR_PORT_B].write_en) begin
      mem[eff_addr[`EBR_PORT_B]] <= req[`EBR_PORT_B].wdata;
    end
  end

  // =====================================================================
  // collision flag for the cycle just written
  // =====================================================================
  always_comb begin
    next_collision = req[`EBR_PORT_A].write_en && req[`EBR_PORT_B].write_en
                     && (eff_addr[`EBR_PORT_A] == eff_addr[`EBR_PORT_B]);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      collision <= 1'b0;
    end else begin
      collision <= next_collision;
    end
  end

  always_comb begin
    rdata_a = rd_out[`EBR_PORT_A];
    rdata_b = rd_out[`EBR_PORT_B];
  end

endmodule : ebr_block_ram

/* File: ebr_block_ram_tb.sv */
// self-checking bench for the block ram ports
`timescale 1ns/1ps
module ebr_block_ram_tb
  import ebr_pkg::*;
;
  typedef struct packed {ebr_cfg_t c; ebr_req_t a, b; ebr_data_t ea, eb;} ebr_row_t;
  logic      clock = 1'b0, rst_n = 1'b0, clash = 1'b0, collision;
  ebr_cfg_t  cfg = 3'h3;
  ebr_req_t  req_a, req_b;
  ebr_data_t rdata_a, rdata_b;
  int        err_count, checks;
  ebr_row_t  rows[4] = '{
    '{3'h3,'{1'b1,1'b1,8'h05,18'h12345},'{1'b1,1'b1,8'h06,18'h0ABCD},18'h12345,18'h0ABCD},
    '{3'h3,'0,'0,18'h12345,18'h0ABCD},
    '{3'h3,'{1'b1,1'b0,8'h00,18'h3FFFF},'{1'b0,1'b1,8'h05,18'h0},18'h3FFFF,18'h12345},
    '{3'h7,'{1'b1,1'b1,8'h90,18'h11111},'{1'b1,1'b1,8'h10,18'h22222},18'h11111,18'h22222}
  };
  always #10 clock = ~clock;
  ebr_fab u_fab (.*);
  ebr_block_ram DUT (.*);
  task automatic chk(string n, ebr_data_t s, ebr_data_t e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step(ebr_cfg_t c, ebr_req_t a, ebr_req_t b);
    u_fab.drive(a, b);
    cfg = c;
    @(posedge clock);
    #1;
  endtask : step
  task automatic conclude;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(posedge clock);
    #1;
    chk("rdata_a", rdata_a, 18'h0);
    chk("rdata_b", rdata_b, 18'h0);
    chk("collision", 18'(collision), 18'h0);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      step(rows[i].c, rows[i].a, rows[i].b);
      chk("rdata_a", rdata_a, rows[i].ea);
      chk("rdata_b", rdata_b, rows[i].eb);
      chk("collision", 18'(collision), 18'h0);
    end
    step(3'h7, '{1'b0,1'b1,8'h90,18'h0}, '{1'b0,1'b1,8'h10,18'h0});
    chk("packed_a", rdata_a, 18'h11111);
    chk("packed_b", rdata_b, 18'h22222);
    // registered outputs: word shows one edge later
    step(3'h0, '{1'b0,1'b1,8'h05,18'h0}, '{1'b0,1'b1,8'h06,18'h0});
    step(3'h0, '{1'b0,1'b1,8'h05,18'h0}, '{1'b0,1'b1,8'h06,18'h0});
    chk("reg_a", rdata_a, 18'h3FFFF);
    chk("reg_b", rdata_b, 18'h0ABCD);
    clash = 1'b1;
    step(3'h3, '{1'b1,1'b1,8'h30,18'h00001}, '{1'b1,1'b1,8'h30,18'h00002});
    chk("collision", 18'(collision), 18'h1);
    // mid-run reset with idle requests
    step(3'h3, '0, '0);
    rst_n = 1'b0;
    #1;
    chk("rst_a", rdata_a, 18'h0);
    chk("rst_b", rdata_b, 18'h0);
    chk("rst_col", 18'(collision), 18'h0);
    @(posedge clock);
    #2;
    rst_n = 1'b1;
    step(3'h3, '{1'b1,1'b0,8'hAA,18'h15555}, '0);
    chk("rst_addr", rdata_a, 18'h15555);
    step(3'h3, '0, '0);
    chk("held_a", rdata_a, 18'h15555);
    conclude();
  end
  // about twenty-six cycles expected
  initial begin
    #2000;
    err_count++;
    conclude();
  end
endmodule : ebr_block_ram_tb

/* File: ebr_chk.sv */
// assertion checker for the block ram ports
`timescale 1ns/1ps
module ebr_chk
  import ebr_pkg::*;
(
  // clock, reset and status
  input logic      clock, rst_n, collision,
  // configuration and requests
  input ebr_cfg_t  cfg,
  input ebr_req_t  req_a, req_b,
  // read data
  input ebr_data_t rdata_a, rdata_b
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_wa; cfg.bypass_a && req_a.write_en && req_a.addr != req_b.addr
    |=> rdata_a == $past(req_a.wdata); endproperty
  a_wa: assert property (p_wa) else $error("port a write not shown");
  property p_hb; cfg.bypass_b && req_b.write_en && req_b.addr_ce ##1 !req_b.addr_ce
    && !req_b.write_en && !req_a.write_en |=> rdata_b == $past(req_b.wdata, 2); endproperty
  a_hb: assert property (p_hb) else $error("port b address not held");
  property p_col; req_a.write_en && req_b.write_en && req_a.addr_ce && req_b.addr_ce
    && req_a.addr == req_b.addr && !cfg.packed_mode |=> collision; endproperty
  a_col: assert property (p_col) else $error("clash not flagged");
  property p_pk; cfg.packed_mode |=> !collision; endproperty
  a_pk: assert property (p_pk) else $error("packed halves overlap");
  property p_wb; cfg.bypass_b && req_b.write_en |=> rdata_b == $past(req_b.wdata); endproperty
  a_wb: assert property (p_wb) else $error("port b write not shown");
  property p_ha; cfg.bypass_a && req_a.write_en && !req_a.addr_ce && !req_b.write_en
    ##1 cfg.bypass_a && !req_a.addr_ce && !req_a.write_en && !req_b.write_en
    |=> rdata_a == $past(req_a.wdata, 2); endproperty
  a_ha: assert property (p_ha) else $error("port a held address not used");
  c_col: cover property (collision);
  c_pk: cover property (cfg.packed_mode);
  c_hold: cover property (!req_b.addr_ce);
endmodule : ebr_chk

bind ebr_block_ram ebr_chk u_chk (.*);

/* File: ebr_fab.sv */
// fabric-side request driver for both ports
`timescale 1ns/1ps
module ebr_fab
  import ebr_pkg::*;
(
  input  wire logic clock,
  input  wire logic clash,
  output ebr_req_t  req_a,
  output ebr_req_t  req_b
);
  initial {req_a, req_b} = '0;
  // ignored lines toggle instead of keeping the last value
  function automatic ebr_req_t rel(ebr_req_t r, ebr_req_t c);
    rel = r;
    if (!r.addr_ce) rel.addr = ~c.addr;
    if (!r.write_en) rel.wdata = ~c.wdata;
  endfunction : rel
  task automatic drive(ebr_req_t a, ebr_req_t b);
    @(posedge clock);
    #2;
    if (a.write_en && b.write_en && a.addr == b.addr && !clash) b.write_en = 1'b0;
    req_a = rel(a, req_a);
    req_b = rel(b, req_b);
  endtask : drive
endmodule : ebr_fab

/* File: ebr_pkg.sv */
// types for the embedded block ram ports
`include "ebr_regs.svh"

package ebr_pkg;

  typedef logic [`EBR_ADDR_W-1:0] ebr_addr_t;
  typedef logic [`EBR_DATA_W-1:0] ebr_data_t;

  // one synchronous port request as driven by fabric logic
  typedef struct packed {
    logic      write_en;
    logic      addr_ce;
    ebr_addr_t addr;
    ebr_data_t wdata;
  } ebr_req_t;

  // block configuration
  typedef struct packed {
    logic packed_mode;
    logic bypass_a;
    logic bypass_b;
  } ebr_cfg_t;

endpackage : ebr_pkg

/* File: ebr_regs.svh */
// constants for the embedded block ram ports
`ifndef EBR_REGS_SVH
`define EBR_REGS_SVH

// =====================================================================
// geometry
// =====================================================================
`define EBR_DATA_W       18
`define EBR_ADDR_W       8
`define EBR_DEPTH        256
`define EBR_HALF_MSB     7

// =====================================================================
// reset values, port indices and port count
// =====================================================================
`define EBR_ADDR_RST     8'h00
`define EBR_DATA_RST     18'h00000
`define EBR_PORT_A       0
`define EBR_PORT_B       1
`define EBR_NUM_PORTS    2

`endif
